// File: core/fbc_pkg.sv
// Package for the flash bus host controller: widths and timing counts
package fbc_pkg;
	// Pin widths
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	// System clock period in ns
	localparam int CLK_PERIOD_NS = 100;
	// Select-to-data access time in ns
	localparam int SELECT_ACCESS_TIME_NS = 90;
	// Address access time in ns
	localparam int ADDRESS_ACCESS_TIME_NS = 90;
	// Least write strobe low width in ns
	localparam int WRITE_PULSE_NS = 35;
	// Least recovery between cycles in ns
	localparam int RECOVERY_NS = 30;
	// Reset pulse width in ns
	localparam int RESET_PULSE_NS = 500;
	// Read wait in cycles, rounded up
	localparam logic [3:0] READ_CYC = 4'((SELECT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Write strobe cycles, rounded up
	localparam logic [3:0] WRITE_CYC = 4'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Recovery cycles, rounded up
	localparam logic [3:0] RECOV_CYC = 4'((RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Reset low cycles, rounded up
	localparam logic [3:0] RESET_CYC = 4'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Controller states, one-hot
	typedef enum logic [4:0] {
		FBC_IDLE = 5'h01,
		FBC_READ = 5'h02,
		FBC_WRITE = 5'h04,
		FBC_RECOV = 5'h08,
		FBC_RESET = 5'h10
	} fbc_state_t;
endpackage

// File: core/fbc_host.sv
// Host controller that drives a parallel NOR flash through its bus pins
// Function
// R1: Read: select and gate low, strobe high.
// R2: Write: strobe and select low, gate high.
// R3: Device floats data while deselected.
// R4: Reset low floats outputs, aborts operations.
// R5: Width select high: all sixteen data pins.
// R6: Width select low: low byte, top pin addresses.
// R7: Word eighteen address bits, byte nineteen.
// R8: Device starts in array read after reset.
// R9: Array read needs no command.
// R10: Command register not mapped at array addresses.
// R11: Program data width follows width select.
// R12: Erase targets sector, sectors or whole array; the model erases only the one 64-byte sector addressed.
// R13: Autoselect returns identification on low byte.
// R14: Status polled by normal reads on low byte.
// R15: Wait select access time before read data.
// R16: Deselection does not abort program or erase.
// R17: Stable addresses bring automatic sleep, data latched.
// R18: Never strobe and gate low together.
`timescale 1ns/10ps
`default_nettype none
module fbc_host (
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	// User request port
	input wire logic I_REQ,
	input wire logic I_WR,
	input wire logic I_BYTE_MODE,
	input wire logic I_DEV_RESET,
	input wire logic [fbc_pkg::ADDR_W:0] I_ADDR,
	input wire logic [fbc_pkg::DATA_W-1:0] I_WDATA,
	output logic O_BUSY,
	output logic O_DONE,
	output logic [fbc_pkg::DATA_W-1:0] O_RDATA,
	// Flash control pins
	output logic O_SEL_N,
	output logic O_GATE_N,
	output logic O_STROBE_N,
	output logic O_RESET_N,
	output logic O_WIDTH_WORD,
	output logic [fbc_pkg::ADDR_W-1:0] O_ADDR,
	// Flash data pins, split into in, out and enable
	input wire logic [fbc_pkg::DATA_W-1:0] I_DQ,
	output logic [fbc_pkg::DATA_W-1:0] O_DQ,
	output logic [fbc_pkg::DATA_W-1:0] O_DQ_OE
);
	import fbc_pkg::*;

	// Current and next state
	fbc_state_t state;
	fbc_state_t next_state;
	// Cycle counter for the active phase
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	// Two-stage synchroniser for the data pins
	logic [DATA_W-1:0] dq_meta;
	logic [DATA_W-1:0] dq_sync;
	// Latched byte mode for the running cycle
	logic byte_q;

	// Decodes of state and counter
	wire logic in_idle = (state == FBC_IDLE);
	wire logic cnt_done = (cnt == 4'h0);
	wire logic take_req = in_idle && I_REQ;
	// Read returns after the pin sync delay too
	wire logic [3:0] read_total = READ_CYC + 4'h2;
	// Byte mode: top data pin carries lowest address bit
	wire logic [DATA_W-1:0] byte_dq = {I_ADDR[0], 7'h00, I_WDATA[7:0]};
	wire logic [DATA_W-1:0] byte_oe = {1'b1, 7'h00, 8'hff};
	// Low byte for byte reads, full word otherwise
	wire logic [DATA_W-1:0] rd_value = byte_q ? {8'h00, dq_sync[7:0]} : dq_sync;

	// Next state selection
	always_comb begin
		next_state = state;
		next_cnt = cnt_done ? 4'h0 : cnt - 4'h1;
		unique case (state)
			FBC_IDLE: begin
				if (I_DEV_RESET) begin
					next_state = FBC_RESET;
					next_cnt = RESET_CYC;
				end else if (I_REQ && I_WR) begin
					next_state = FBC_WRITE;
					next_cnt = WRITE_CYC;
				end else if (I_REQ) begin
					next_state = FBC_READ;
					next_cnt = read_total;
				end
			end
			FBC_READ: begin
				if (cnt_done) begin
					next_state = FBC_RECOV;
					next_cnt = RECOV_CYC;
				end
			end
			FBC_WRITE: begin
				if (cnt_done) begin
					next_state = FBC_RECOV;
					next_cnt = RECOV_CYC;
				end
			end
			FBC_RECOV: begin
				if (cnt_done) begin
					next_state = FBC_IDLE;
				end
			end
			FBC_RESET: begin
				if (cnt_done) begin
					next_state = FBC_RECOV;
					next_cnt = RECOV_CYC;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			state <= FBC_IDLE;
			cnt <= 4'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// Data pin synchroniser; pins come from outside the clock domain
	always_ff @(posedge I_CLK_SYS) begin
		dq_meta <= I_DQ;
		dq_sync <= dq_meta;
	end

	// Control pins; all deasserted in reset so the flash idles
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			O_SEL_N <= 1'b1;
			O_GATE_N <= 1'b1;
			O_STROBE_N <= 1'b1;
			O_RESET_N <= 1'b1;
		end else begin
			// R1: read levels
			// R2: write levels
			// R18: strobe and gate exclusive
			O_SEL_N <= !(next_state == FBC_READ || next_state == FBC_WRITE);
			O_GATE_N <= !(next_state == FBC_READ);
			O_STROBE_N <= !(next_state == FBC_WRITE);
			// R4: reset pulse out
			O_RESET_N <= !(next_state == FBC_RESET);
		end
	end

	// Address, width and data drive, latched at request
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			O_ADDR <= '0;
			O_WIDTH_WORD <= 1'b1;
			O_DQ <= '0;
			O_DQ_OE <= '0;
			byte_q <= 1'b0;
		end else if (take_req && !I_DEV_RESET) begin
			// R7: word uses bits 18:1, byte adds bit 0
			O_ADDR <= I_ADDR[ADDR_W:1];
			// R5: word width select
			// R6: byte width select
			O_WIDTH_WORD <= !I_BYTE_MODE;
			byte_q <= I_BYTE_MODE;
			// R11: program data width
			O_DQ <= I_BYTE_MODE ? byte_dq : I_WDATA;
			// Write drives data; byte read still drives the address pin
			O_DQ_OE <= I_WR ? (I_BYTE_MODE ? byte_oe : '1) : (I_BYTE_MODE ? {1'b1, 15'h0000} : '0);
		end else if (in_idle) begin
			// Release data pins between cycles
			O_DQ_OE <= '0;
		end
	end

	// Handshake outputs and captured read data
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			O_BUSY <= 1'b0;
			O_DONE <= 1'b0;
			O_RDATA <= '0;
		end else begin
			O_BUSY <= (next_state != FBC_IDLE);
			O_DONE <= (state != FBC_IDLE) && (next_state == FBC_IDLE);
			// R15: sample after access time
			// R14: status via normal read
			if (state == FBC_READ && cnt_done) begin
				O_RDATA <= rd_value;
			end
		end
	end

	// Read strobe width tracker for the assertions
	logic [3:0] gate_len;
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST || O_GATE_N) begin
			gate_len <= 4'h0;
		end else if (gate_len != 4'hf) begin
			gate_len <= gate_len + 4'h1;
		end
	end

	property p_excl;
		@(posedge I_CLK_SYS) disable iff (I_RST) !(!O_GATE_N && !O_STROBE_N);
	endproperty
	a_excl: assert property (p_excl) else $error("strobe and gate low together"); // R18

	property p_read_sel;
		@(posedge I_CLK_SYS) disable iff (I_RST) !O_GATE_N |-> !O_SEL_N && O_STROBE_N;
	endproperty
	a_read_sel: assert property (p_read_sel) else $error("read without select"); // R1

	property p_write_sel;
		@(posedge I_CLK_SYS) disable iff (I_RST) !O_STROBE_N |-> !O_SEL_N && O_GATE_N;
	endproperty
	a_write_sel: assert property (p_write_sel) else $error("write levels wrong"); // R2

	sequence s_gate_fall;
		$fell(O_GATE_N);
	endsequence
	property p_access;
		@(posedge I_CLK_SYS) disable iff (I_RST) s_gate_fall |-> !O_GATE_N [*2];
	endproperty
	a_access: assert property (p_access) else $error("read shorter than access time"); // R15

	property p_done_gap;
		@(posedge I_CLK_SYS) disable iff (I_RST) $rose(O_GATE_N) && gate_len < read_total |-> 1'b0;
	endproperty
	a_done_gap: assert property (p_done_gap) else $error("read ended early"); // R15

	property p_reset_float;
		@(posedge I_CLK_SYS) disable iff (I_RST) !O_RESET_N |-> O_SEL_N && O_DQ_OE == '0;
	endproperty
	a_reset_float: assert property (p_reset_float) else $error("bus active in reset"); // R4

	property p_byte_pins;
		@(posedge I_CLK_SYS) disable iff (I_RST) !O_WIDTH_WORD |-> O_DQ_OE[14:8] == 7'h00;
	endproperty
	a_byte_pins: assert property (p_byte_pins) else $error("byte mode drives middle pins"); // R6

	property p_read_float;
		@(posedge I_CLK_SYS) disable iff (I_RST) !O_GATE_N |-> O_DQ_OE[7:0] == 8'h00;
	endproperty
	a_read_float: assert property (p_read_float) else $error("contention on read"); // R1

	property p_done_pulse;
		@(posedge I_CLK_SYS) disable iff (I_RST) O_DONE |=> !O_DONE;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle"); // done handshake
endmodule
`default_nettype wire

// File: verification/fbc_flash_model.sv
// Behavioural flash device seen by the host controller
`timescale 1ns/10ps
`default_nettype none
module fbc_flash_model #(
	parameter int ACC_NS = fbc_pkg::SELECT_ACCESS_TIME_NS,
	// Command bytes on the low data pins; values are arbitrary
	parameter logic [7:0] CMD_AUTOSEL = 8'h5a,
	parameter logic [7:0] CMD_ERASE = 8'he1,
	// Identification byte; value is arbitrary
	parameter logic [7:0] ID_CODE = 8'h3e,
	// Status byte while erasing; value is arbitrary
	parameter logic [7:0] STATUS_BUSY = 8'h48,
	// Erase run time in ns
	parameter int ERASE_NS = 1500
) (
	// Control pins, active low except the width select
	input wire logic i_sel_n,
	input wire logic i_gate_n,
	input wire logic i_strobe_n,
	input wire logic i_reset_n,
	input wire logic i_width_word,
	// Address and resolved data bus
	input wire logic [17:0] i_addr,
	input wire logic [15:0] i_dq,
	output logic [15:0] o_dq,
	output logic [15:0] o_dq_oe
);
	import fbc_pkg::*;
	// Small byte array, upper address bits alias
	logic [7:0] mem [0:511];
	logic valid = 1'b0;
	// Autoselect mode and running erase; both cleared by reset
	logic autosel = 1'b0;
	logic erasing = 1'b0;
	// byte mode takes the lowest bit from the top data pin
	wire logic [8:0] lo = {i_addr[7:0], i_width_word ? 1'b0 : i_dq[15]};
	wire logic rd_en = !i_sel_n && !i_gate_n && i_strobe_n && i_reset_n && valid;
	// Write cycle open; committing on its fall avoids racing the address update
	wire logic wr_act = !i_strobe_n && !i_sel_n && i_gate_n && i_reset_n;
	// identification or status byte instead of array data
	wire logic [7:0] alt_byte = erasing ? STATUS_BUSY : ID_CODE;
	// float unless reading; byte mode drives low byte
	assign o_dq_oe = rd_en ? (i_width_word ? 16'hffff : 16'h00ff) : 16'h0000;
	// output follows the held address, so it stays latched while idle
	assign o_dq = (autosel || erasing) ? {8'h00, alt_byte} :
		(i_width_word ? {mem[lo | 9'h001], mem[lo]} : {8'h00, mem[lo]});
	// data only after the select access time
	always @(i_sel_n) begin
		valid = 1'b0;
		if (!i_sel_n) valid <= #(ACC_NS) 1'b1;
	end
	// command bytes are never stored as array data; reset aborts all
	always @(negedge wr_act or negedge i_reset_n) begin
		if (!i_reset_n) begin
			autosel = 1'b0;
			erasing = 1'b0;
		end else if (i_dq[7:0] == CMD_AUTOSEL) begin
			autosel = 1'b1;
		end else if (i_dq[7:0] == CMD_ERASE) begin
			// high address bits pick the sector
			for (int i = 0; i < 64; i++) begin
				mem[{lo[8:6], 6'(i)}] = 8'hff;
			end
			erasing = 1'b1;
			// runs to its end whether selected or not
			erasing <= #(ERASE_NS) 1'b0;
		end else begin
			mem[lo] = i_dq[7:0];
			if (i_width_word) mem[lo | 9'h001] = i_dq[15:8];
		end
	end
endmodule
`default_nettype wire

// File: verification/fbc_host_tb_top.sv
// Self-checking bench for the flash bus host controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin failures++; $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module fbc_host_tb_top;
	import fbc_pkg::*;
	logic I_CLK_SYS, I_RST, I_REQ, I_WR, I_BYTE_MODE, I_DEV_RESET;
	logic [18:0] I_ADDR;
	logic [15:0] I_WDATA;
	wire logic O_BUSY, O_DONE, O_SEL_N, O_GATE_N, O_STROBE_N, O_RESET_N, O_WIDTH_WORD;
	wire logic [17:0] O_ADDR;
	wire logic [15:0] O_RDATA, O_DQ, O_DQ_OE, dev_dq, dev_oe, dq_bus;
	logic [15:0] flt = 16'haaaa;
	int failures = 0;
	int tests_run = 0;
	// Model command, identity and status bytes; values are arbitrary
	localparam logic [7:0] CMD_AUTOSEL = 8'h5a;
	localparam logic [7:0] CMD_ERASE = 8'he1;
	localparam logic [7:0] ID_CODE = 8'h3e;
	localparam logic [7:0] STATUS_BUSY = 8'h48;
	// Model erase run time in ns
	localparam int ERASE_NS = 1500;
	// Pin values seen while selected
	logic [17:0] seen_addr;
	logic [15:0] seen_oe;
	logic seen_w;
	int low_cnt, clash, gap;
	// Undriven lines change every cycle, never hold
	always @(posedge I_CLK_SYS) flt <= ~flt;
	assign dq_bus = (O_DQ & O_DQ_OE) | (dev_dq & dev_oe) | (flt & ~(O_DQ_OE | dev_oe));
	fbc_host dut_u (.I_CLK_SYS, .I_RST, .I_REQ, .I_WR, .I_BYTE_MODE, .I_DEV_RESET, .I_ADDR, .I_WDATA,
		.O_BUSY, .O_DONE, .O_RDATA, .O_SEL_N, .O_GATE_N, .O_STROBE_N, .O_RESET_N, .O_WIDTH_WORD,
		.O_ADDR, .I_DQ(dq_bus), .O_DQ, .O_DQ_OE);
	fbc_flash_model #(.CMD_AUTOSEL(CMD_AUTOSEL), .CMD_ERASE(CMD_ERASE), .ID_CODE(ID_CODE),
		.STATUS_BUSY(STATUS_BUSY), .ERASE_NS(ERASE_NS))
		flash_u (.i_sel_n(O_SEL_N), .i_gate_n(O_GATE_N), .i_strobe_n(O_STROBE_N),
		.i_reset_n(O_RESET_N), .i_width_word(O_WIDTH_WORD), .i_addr(O_ADDR), .i_dq(dq_bus),
		.o_dq(dev_dq), .o_dq_oe(dev_oe));
	// 10 MHz clock
	initial begin
		I_CLK_SYS = 1'b0;
		forever #50 I_CLK_SYS = ~I_CLK_SYS;
	end
	task automatic give_verdict();
		$display("counts: %0d compares, %0d mismatches", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One request from a falling edge, watched until done
	task automatic op(input logic rst, wr, byt, input logic [18:0] a, input logic [15:0] d);
		int n;
		I_DEV_RESET = rst;
		I_REQ = !rst;
		I_WR = wr;
		I_BYTE_MODE = byt;
		I_ADDR = a;
		I_WDATA = d;
		low_cnt = 0;
		gap = 0;
		@(negedge I_CLK_SYS);
		I_REQ = 1'b0;
		I_DEV_RESET = 1'b0;
		for (n = 0; n < 40 && O_DONE !== 1'b1; n++) begin
			if (O_SEL_N === 1'b0) begin
				seen_addr = O_ADDR;
				seen_oe = O_DQ_OE;
				seen_w = O_WIDTH_WORD;
			end
			if (O_RESET_N === 1'b0) low_cnt++;
			// Busy must stand from the take until done
			if (O_BUSY !== 1'b1) gap++;
			if (O_GATE_N === 1'b0 && O_STROBE_N === 1'b0) clash++;
			@(negedge I_CLK_SYS);
		end
		// Hung transfer ends the run
		if (n == 40) begin
			failures++;
			give_verdict();
		end
	endtask
	task automatic t_word();
		`CHK({O_SEL_N, O_GATE_N, O_STROBE_N, O_RESET_N, O_BUSY, O_DQ_OE}, 21'h1e0000) // idle pins
		op(1'b0, 1'b1, 1'b0, 19'h00010, 16'ha5c3);
		`CHK(seen_oe, 16'hffff) // write drives data
		op(1'b0, 1'b0, 1'b0, 19'h00010, 16'h0000);
		`CHK(O_RDATA, 16'ha5c3) // word read back
		`CHK({seen_w, seen_oe}, 17'h10000) // word width, bus released
		`CHK(seen_addr, 18'h00008) // address bits
		`CHK(gap, 0) // busy through the whole read
		$display("test word done");
	endtask
	task automatic t_byte();
		op(1'b0, 1'b1, 1'b1, 19'h00021, 16'h003c);
		`CHK(seen_oe, 16'h80ff) // low byte plus address pin
		op(1'b0, 1'b1, 1'b1, 19'h00020, 16'hff96);
		op(1'b0, 1'b0, 1'b1, 19'h00021, 16'h0000);
		`CHK(O_RDATA, 16'h003c) // byte stored, upper zero
		`CHK({seen_w, seen_oe}, 17'h08000) // byte width pin
		op(1'b0, 1'b0, 1'b0, 19'h00020, 16'h0000);
		`CHK(O_RDATA, 16'h3c96) // bytes pair into a word
		$display("test byte done");
	endtask
	task automatic t_reset();
		op(1'b0, 1'b1, 1'b0, 19'h00000, {8'h00, CMD_AUTOSEL});
		op(1'b0, 1'b0, 1'b0, 19'h00002, 16'h0000);
		`CHK(O_RDATA, {8'h00, ID_CODE}) // identification on low byte
		op(1'b1, 1'b0, 1'b0, 19'h00000, 16'h0000);
		`CHK(low_cnt >= int'(RESET_CYC), 1'b1) // reset pulse long enough
		op(1'b0, 1'b0, 1'b0, 19'h00010, 16'h0000);
		`CHK(O_RDATA, 16'ha5c3) // array read after reset
		`CHK(clash, 0) // strobe and gate never low together
		$display("test reset done");
	endtask
	// Erase one sector, poll status, then check both sectors
	task automatic t_erase();
		op(1'b0, 1'b1, 1'b0, 19'h00040, {8'h00, CMD_ERASE});
		op(1'b0, 1'b0, 1'b0, 19'h00010, 16'h0000);
		`CHK(O_RDATA, {8'h00, STATUS_BUSY}) // status while erasing
		repeat (ERASE_NS / CLK_PERIOD_NS) @(negedge I_CLK_SYS);
		op(1'b0, 1'b0, 1'b0, 19'h00040, 16'h0000);
		`CHK(O_RDATA, 16'hffff) // addressed sector erased
		op(1'b0, 1'b0, 1'b0, 19'h00010, 16'h0000);
		`CHK(O_RDATA, 16'ha5c3) // other sector kept
		$display("test erase done");
	endtask
	// Main sequence, reset held 20 cycles
	initial begin
		I_RST = 1'b1;
		I_REQ = 1'b0;
		I_WR = 1'b0;
		I_BYTE_MODE = 1'b0;
		I_DEV_RESET = 1'b0;
		I_ADDR = 19'h00000;
		I_WDATA = 16'h0000;
		clash = 0;
		repeat (20) @(posedge I_CLK_SYS);
		@(negedge I_CLK_SYS);
		I_RST = 1'b0;
		@(negedge I_CLK_SYS);
		t_word();
		t_byte();
		t_reset();
		t_erase();
		give_verdict();
	end
endmodule
`default_nettype wire
